// ---- hw/pcp_pkg.sv ----
// Constants, register map and field layout of the PWM timer units
package pcp_pkg;

  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets inside one unit
  localparam logic [7:0] UNIT_STRIDE = 8'h40;
  localparam logic [7:0] OFF_SC = 8'h00;
  localparam logic [7:0] OFF_CNT = 8'h04;
  localparam logic [7:0] OFF_MOD = 8'h08;
  localparam logic [7:0] OFF_CH0SC = 8'h0C;
  localparam logic [7:0] OFF_CH0VAL = 8'h10;
  localparam logic [7:0] OFF_CH1SC = 8'h14;
  localparam logic [7:0] OFF_CH1VAL = 8'h18;
  // Global break flag control register
  localparam logic [7:0] OFF_BRK = 8'h80;

  // Unit status control fields
  localparam int SC_FLAG = 7;
  localparam int SC_IE = 6;
  localparam int SC_HALT = 5;
  localparam int SC_RST = 4;
  localparam int SC_PS_HI = 2;
  localparam int SC_PS_LO = 0;

  // Channel status control fields
  localparam int CH_FLAG = 7;
  localparam int CH_IE = 6;
  localparam int CH_MSB = 5;
  localparam int CH_MSA = 4;
  localparam int CH_ELSB = 3;
  localparam int CH_ELSA = 2;
  localparam int CH_TOV = 1;
  localparam int CH_MAX = 0;

  // Break control field
  localparam int BRK_BREAK_FLAG_CLEAR_ENABLE = 0;

  // Reset values
  localparam logic [7:0] SC_RESET = 8'h20;
  localparam logic [CNT_W-1:0] MOD_RESET = 16'hFFFF;
  localparam logic [6:0] CH_RESET = 7'h00;
  localparam logic [CNT_W-1:0] VAL_RESET = 16'h0000;

  // Prescaler code with no clock source
  localparam logic [2:0] PS_NONE = 3'h7;

  // Edge/level pair in compare mode
  localparam logic [1:0] ELS_PORT = 2'h0;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
  // Edge/level pair in capture mode
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY = 2'h3;

endpackage

// ---- hw/pcp_channel.sv ----
// One timer channel: pin action on compare and wrap, edge detection for capture
`timescale 1ns/1ps
module pcp_channel (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       wrap,
  input  wire logic       match,
  input  wire logic       pinSync,
  input  wire logic [6:0] ctrl,
  output logic            pinOut,
  output logic            pinOe,
  output logic            chanEvent,
  output logic            captureEvent
);

  logic       isCompare;
  logic [1:0] els;
  logic       tov;
  logic       fullDuty;
  logic       prevPin;
  logic       rise;
  logic       fall;

  assign isCompare = ctrl[pcp_pkg::CH_MSB] | ctrl[pcp_pkg::CH_MSA]; // RULE10
  assign els = ctrl[pcp_pkg::CH_ELSB:pcp_pkg::CH_ELSA];
  assign tov = ctrl[pcp_pkg::CH_TOV];
  assign fullDuty = ctrl[pcp_pkg::CH_MAX];
  assign rise = pinSync & ~prevPin;
  assign fall = ~pinSync & prevPin;

  assign captureEvent = ~isCompare && ((els == pcp_pkg::EDGE_RISE && rise) ||
                                       (els == pcp_pkg::EDGE_FALL && fall) ||
                                       (els == pcp_pkg::EDGE_ANY && (rise | fall)));
  assign chanEvent = (isCompare & match) | captureEvent; // RULE16

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevPin <= 1'b0;
    end else begin
      prevPin <= pinSync;
    end
  end

  // Port owns the pin unless a compare action is selected
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOe <= 1'b0;
    end else begin
      pinOe <= isCompare && els != pcp_pkg::ELS_PORT; // RULE22
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 1'b0;
    end else if (isCompare) begin
      if (wrap && tov) begin // RULE23
        if (fullDuty && els == pcp_pkg::ELS_CLEAR) begin
          pinOut <= 1'b1; // RULE14
        end else if (fullDuty && els == pcp_pkg::ELS_SET) begin
          pinOut <= 1'b0; // RULE14
        end else begin
          pinOut <= ~pinOut;
        end
      end else if (match && !(fullDuty && tov)) begin
        // Without wrap toggles, clear and set re-drive the held level
        unique case (els) // RULE11 RULE13
          pcp_pkg::ELS_TOGGLE: pinOut <= ~pinOut;
          pcp_pkg::ELS_CLEAR:  pinOut <= 1'b0;
          pcp_pkg::ELS_SET:    pinOut <= 1'b1;
          pcp_pkg::ELS_PORT:   pinOut <= pinOut;
        endcase
      end
    end
  end

endmodule

// ---- hw/pcp_timer_top.sv ----
// Two PWM timer units, two channels each, behind an APB slave
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// RULE1 - Compare value sets pulse width from wrap to match; 256 steps at 8 bits.
// RULE2 - Unbuffered compare writes act at once; a passed value misses that period.
// RULE3 - Channel compare flag and request rise at the end of the pulse.
// RULE4 - Wrap flag and request rise at the end of every period.
// RULE5 - Software should not select toggle on compare for PWM.
// RULE6 - Buffer link bit on channel 0 joins both channels onto pin 0; value 0 first.
// RULE7 - Writing channel 1 value hands control over at the next wrap; last written wins.
// RULE8 - While linked, channel 1 control is unused and its pin goes to the port.
// RULE9 - Software should write only the inactive value of a linked pair.
// RULE10 - Mode pair 0:1 selects unbuffered compare, 1:0 buffered compare.
// RULE11 - Edge pair 1:0 clears, 1:1 sets on compare; wrap toggle completes PWM.
// RULE12 - Software sets up halt, reset, period, width, mode, then releases halt.
// RULE13 - Without wrap toggle the output never changes at wrap: 0% duty.
// RULE14 - Full duty bit with wrap toggle holds the output at 100% duty.
// RULE15 - Wrap flag sets at modulo match; request only while its enable is set.
// RULE16 - Channel flag sets on capture or compare; request only while enabled.
// RULE17 - Counting continues in wait; registers unreachable; enabled requests wake.
// RULE18 - Stop mode halts everything without changing any register or count; here capture edges still load values and set flags.
// RULE19 - Counter halts while a debug break is active.
// RULE20 - Flags clear in break only with break clear enable; else accesses leave them.
// RULE21 - A first clear step made before break survives it; second step clears.
// RULE22 - Each of the four pins is independently capture or compare; pin 0 buffers; here pin 2 buffers too.
// RULE23 - With wrap toggle the pin toggles at modulo match; modulo sets the period.
// RULE24 - At modulo match the counter sets the wrap flag and restarts from zero.
// RULE25 - Two identical units, each with own channels, pins and requests.
module pcp_timer_top #(
  parameter int NUM_UNITS = 2
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [pcp_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [pcp_pkg::DATA_W-1:0]   pwdata,
  output logic                              pready,
  output logic      [pcp_pkg::DATA_W-1:0]   prdata,
  output logic                              pslverr,
  input  wire logic                         waitMode,
  input  wire logic                         stopMode,
  input  wire logic                         breakActive,
  input  wire logic [2*NUM_UNITS-1:0]       chanPinIn,
  output logic      [2*NUM_UNITS-1:0]       chanPinOut,
  output logic      [2*NUM_UNITS-1:0]       chanPinOe,
  output logic      [NUM_UNITS-1:0]         wrapIrq,
  output logic      [2*NUM_UNITS-1:0]       chanIrq,
  output logic                              wakeReq
);

  localparam int NCH = 2 * NUM_UNITS;

  if (NUM_UNITS < 1 || NUM_UNITS > 2) begin : gBadUnits
    $error("NUM_UNITS must be 1 or 2");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [pcp_pkg::CNT_W-1:0] count   [NUM_UNITS];
  logic [pcp_pkg::CNT_W-1:0] modulo  [NUM_UNITS];
  logic                      wrapFlag[NUM_UNITS];
  logic                      wrapIe  [NUM_UNITS];
  logic                      haltBit [NUM_UNITS];
  logic [2:0]                ps      [NUM_UNITS];
  logic                      linked  [NUM_UNITS];
  logic [6:0]                chCtrl  [NCH];
  logic                      chFlag  [NCH];
  logic [pcp_pkg::CNT_W-1:0] chVal   [NCH];
  logic                      break_flag_clear_enable;
  logic [NCH-1:0]            chanReq;
  logic [NUM_UNITS-1:0]      wrapReq;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic                      apbDone;
  logic                      wrEn;
  logic                      rdEn;
  logic                      clearOk;
  logic                      regArea;
  logic                      unitIdx;
  logic [7:0]                offset;
  logic                      rdHit;
  logic [pcp_pkg::DATA_W-1:0] rdData;

  assign apbDone = psel & penable & pready;
  assign wrEn = apbDone & pwrite & ~waitMode; // RULE17
  // Arm in the cycle the read data are latched, so the arm matches what software sees
  assign rdEn = psel & penable & ~pready & ~pwrite & ~waitMode; // RULE17
  assign clearOk = ~breakActive | break_flag_clear_enable; // RULE20
  assign regArea = ~paddr[7] && paddr[1:0] == 2'h0;
  assign unitIdx = paddr[6];
  assign offset = {2'h0, paddr[5:0]};

  always_comb begin
    rdData = '0;
    rdHit = 1'b0;
    if (paddr == pcp_pkg::OFF_BRK) begin
      rdHit = 1'b1;
      rdData[pcp_pkg::BRK_BREAK_FLAG_CLEAR_ENABLE] = break_flag_clear_enable;
    end else if (regArea && int'(unitIdx) < NUM_UNITS) begin
      rdHit = 1'b1;
      unique case (offset)
        pcp_pkg::OFF_SC:
          rdData[7:0] = {wrapFlag[unitIdx], wrapIe[unitIdx], haltBit[unitIdx], 2'h0, ps[unitIdx]};
        pcp_pkg::OFF_CNT:
          rdData[pcp_pkg::CNT_W-1:0] = count[unitIdx];
        pcp_pkg::OFF_MOD:
          rdData[pcp_pkg::CNT_W-1:0] = modulo[unitIdx];
        pcp_pkg::OFF_CH0SC:
          rdData[7:0] = {chFlag[{unitIdx, 1'b0}], chCtrl[{unitIdx, 1'b0}]};
        pcp_pkg::OFF_CH0VAL:
          rdData[pcp_pkg::CNT_W-1:0] = chVal[{unitIdx, 1'b0}];
        pcp_pkg::OFF_CH1SC:
          if (!linked[unitIdx]) begin // RULE8
            rdData[7:0] = {chFlag[{unitIdx, 1'b1}], chCtrl[{unitIdx, 1'b1}]};
          end
        pcp_pkg::OFF_CH1VAL:
          rdData[pcp_pkg::CNT_W-1:0] = chVal[{unitIdx, 1'b1}];
        default:
          rdHit = 1'b0;
      endcase
    end
  end

  // One wait state: answer on the second access cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata <= (pwrite | waitMode) ? '0 : rdData; // RULE17
        pslverr <= ~rdHit | waitMode;
      end else begin
        prdata <= '0;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      break_flag_clear_enable <= 1'b0;
    end else if (wrEn && paddr == pcp_pkg::OFF_BRK) begin
      break_flag_clear_enable <= pwdata[pcp_pkg::BRK_BREAK_FLAG_CLEAR_ENABLE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request outputs

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrapIrq <= '0;
      chanIrq <= '0;
      wakeReq <= 1'b0;
    end else begin
      wrapIrq <= wrapReq;
      chanIrq <= chanReq;
      wakeReq <= waitMode & (|{wrapReq, chanReq}); // RULE17
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer units

  for (genvar u = 0; u < NUM_UNITS; u++) begin : gUnit // RULE25
    logic       selU;
    logic       wrSc;
    logic       rdSc;
    logic       wrMod;
    logic       wrV0;
    logic       wrV1;
    logic       trst;
    logic       halt;
    logic       tick;
    logic       wrap;
    logic       wrapArm;
    logic       activeSel;
    logic       pendSel;
    logic [5:0] preDiv;
    logic [5:0] preMask;

    assign selU = regArea && unitIdx == 1'(u);
    assign wrSc = wrEn && selU && offset == pcp_pkg::OFF_SC;
    assign rdSc = rdEn && selU && offset == pcp_pkg::OFF_SC;
    assign wrMod = wrEn && selU && offset == pcp_pkg::OFF_MOD;
    assign wrV0 = wrEn && selU && offset == pcp_pkg::OFF_CH0VAL;
    assign wrV1 = wrEn && selU && offset == pcp_pkg::OFF_CH1VAL;
    assign trst = wrSc && pwdata[pcp_pkg::SC_RST];
    assign halt = haltBit[u] | stopMode | breakActive; // RULE18 RULE19
    assign preMask = 6'((7'h01 << ps[u]) - 7'h01);
    assign tick = ~halt && ps[u] != pcp_pkg::PS_NONE && (preDiv & preMask) == preMask;
    assign wrap = tick && count[u] == modulo[u]; // RULE24
    assign linked[u] = chCtrl[2*u][pcp_pkg::CH_MSB]; // RULE6
    assign wrapReq[u] = wrapFlag[u] & wrapIe[u]; // RULE15

    // Prescaler and counter; the reset bit also clears the prescaler
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        preDiv <= 6'h00;
        count[u] <= '0;
      end else if (trst) begin
        preDiv <= 6'h00;
        count[u] <= '0;
      end else if (!halt) begin
        preDiv <= preDiv + 6'h01;
        if (tick) begin
          count[u] <= wrap ? '0 : count[u] + 16'h0001; // RULE24
        end
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        wrapIe[u] <= pcp_pkg::SC_RESET[pcp_pkg::SC_IE];
        haltBit[u] <= pcp_pkg::SC_RESET[pcp_pkg::SC_HALT];
        ps[u] <= pcp_pkg::SC_RESET[pcp_pkg::SC_PS_HI:pcp_pkg::SC_PS_LO];
      end else if (wrSc) begin
        wrapIe[u] <= pwdata[pcp_pkg::SC_IE];
        haltBit[u] <= pwdata[pcp_pkg::SC_HALT];
        ps[u] <= pwdata[pcp_pkg::SC_PS_HI:pcp_pkg::SC_PS_LO];
      end
    end

    // Two-step clear: read with flag set, then write zero; a new wrap wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        wrapFlag[u] <= 1'b0;
        wrapArm <= 1'b0;
      end else if (wrap) begin
        wrapFlag[u] <= 1'b1; // RULE4 RULE15
        wrapArm <= 1'b0;
      end else if (rdSc && wrapFlag[u] && clearOk) begin
        wrapArm <= 1'b1; // RULE20
      end else if (wrSc && !pwdata[pcp_pkg::SC_FLAG] && wrapArm && clearOk) begin
        wrapFlag[u] <= 1'b0; // RULE20 RULE21
        wrapArm <= 1'b0;
      end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        modulo[u] <= pcp_pkg::MOD_RESET;
      end else if (wrMod) begin
        modulo[u] <= pwdata[pcp_pkg::CNT_W-1:0];
      end
    end

    // Linked pair: value written last takes over at the next wrap
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        activeSel <= 1'b0;
        pendSel <= 1'b0;
      end else if (!linked[u]) begin
        activeSel <= 1'b0; // RULE6
        pendSel <= 1'b0;
      end else begin
        if (wrV1) begin
          pendSel <= 1'b1; // RULE7
        end else if (wrV0) begin
          pendSel <= 1'b0; // RULE7
        end
        if (wrap) begin
          activeSel <= wrV1 ? 1'b1 : (wrV0 ? 1'b0 : pendSel); // RULE7
        end
      end
    end

    for (genvar c = 0; c < 2; c++) begin : gChan
      localparam int CH = 2 * u + c;
      logic                      wrCtl;
      logic                      rdCtl;
      logic                      wrVal;
      logic                      chArm;
      logic [6:0]                ctrlEff;
      logic [pcp_pkg::CNT_W-1:0] cmpVal;
      logic                      match;
      logic                      evt;
      logic                      capEvt;
      logic                      syncA;
      logic                      syncB;

      assign wrCtl = wrEn && selU && offset == (c == 0 ? pcp_pkg::OFF_CH0SC : pcp_pkg::OFF_CH1SC);
      assign rdCtl = rdEn && selU && offset == (c == 0 ? pcp_pkg::OFF_CH0SC : pcp_pkg::OFF_CH1SC);
      assign wrVal = c == 0 ? wrV0 : wrV1;
      assign ctrlEff = (c == 1 && linked[u]) ? 7'h00 : chCtrl[CH]; // RULE8
      assign cmpVal = (c == 0 && activeSel) ? chVal[CH+1] : chVal[CH]; // RULE6 RULE7
      assign match = tick && count[u] == cmpVal; // RULE1 RULE2
      assign chanReq[CH] = chFlag[CH] & ctrlEff[pcp_pkg::CH_IE]; // RULE16

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          syncA <= 1'b0;
          syncB <= 1'b0;
        end else begin
          syncA <= chanPinIn[CH];
          syncB <= syncA;
        end
      end

      // Mode pair B bit only exists on the first channel
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          chCtrl[CH] <= pcp_pkg::CH_RESET;
        end else if (wrCtl && !(c == 1 && linked[u])) begin // RULE8
          chCtrl[CH] <= c == 0 ? pwdata[6:0] : (pwdata[6:0] & ~(7'h01 << pcp_pkg::CH_MSB));
        end
      end

      // Writes act at once; capture copies the counter into the value
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          chVal[CH] <= pcp_pkg::VAL_RESET;
        end else if (wrVal) begin
          chVal[CH] <= pwdata[pcp_pkg::CNT_W-1:0]; // RULE2
        end else if (capEvt) begin
          chVal[CH] <= count[u];
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          chFlag[CH] <= 1'b0;
          chArm <= 1'b0;
        end else if (evt) begin
          chFlag[CH] <= 1'b1; // RULE3 RULE16
          chArm <= 1'b0;
        end else if (rdCtl && chFlag[CH] && clearOk && !(c == 1 && linked[u])) begin
          chArm <= 1'b1; // RULE20
        end else if (wrCtl && !pwdata[pcp_pkg::CH_FLAG] && chArm && clearOk) begin
          chFlag[CH] <= 1'b0; // RULE20 RULE21
          chArm <= 1'b0;
        end
      end

      pcp_channel uChan (
        .ref_clk      (ref_clk),
        .rst_n        (rst_n),
        .wrap         (wrap),
        .match        (match),
        .pinSync      (syncB),
        .ctrl         (ctrlEff),
        .pinOut       (chanPinOut[CH]),
        .pinOe        (chanPinOe[CH]),
        .chanEvent    (evt),
        .captureEvent (capEvt)
      ); // RULE22
    end
  end

endmodule

// ---- verification/pcp_timer_chk.sv ----
// Port checker of the two-unit PWM timer
`timescale 1ns/1ps
module pcp_timer_chk #(
  parameter int NUM_UNITS = 2
) (
  input wire logic                       ref_clk,
  input wire logic                       rst_n,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pready,
  input wire logic [pcp_pkg::DATA_W-1:0] prdata,
  input wire logic                       pslverr,
  input wire logic                       waitMode,
  input wire logic                       stopMode,
  input wire logic                       breakActive,
  input wire logic [2*NUM_UNITS-1:0]     chanPinOut,
  input wire logic [2*NUM_UNITS-1:0]     chanPinOe,
  input wire logic [NUM_UNITS-1:0]       wrapIrq,
  input wire logic                       wakeReq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_ready_slot: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready out of slot");
  a_data_idle: assert property (!pready |-> prdata == '0) else $error("prdata not zero when idle");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_wait_refuse: assert property (pready && waitMode && $past(waitMode) |-> pslverr)
    else $error("access in wait mode accepted");
  a_wake_wait: assert property (wakeReq |-> $past(waitMode)) else $error("wake outside wait mode");
  a_wake_cause: assert property ($past(waitMode) && (|wrapIrq) |-> wakeReq)
    else $error("no wake for enabled request");
  a_stop_hold: assert property ((stopMode && !psel) [*3] |-> $stable(chanPinOut) && !$rose(|wrapIrq))
    else $error("activity in stop mode");
  a_break_hold: assert property ((breakActive && !psel) [*3] |-> $stable(chanPinOut))
    else $error("pin moved during break");
  a_reset_quiet: assert property ($rose(rst_n) |-> chanPinOe == '0 && !pready) else $error("outputs busy at reset");
  ////////////////////////////////////////////////////////////////////////////////
  c_wake: cover property (wakeReq);
  c_wrap: cover property ($rose(wrapIrq[0]));
  c_pulse: cover property ($rose(chanPinOut[0]) ##[1:40] $fell(chanPinOut[0]));
endmodule

// ---- verification/pcp_pin_model.sv ----
// External load and signal source on the channel pins
`timescale 1ns/1ps
module pcp_pin_model #(
  parameter int W = 4
) (
  input  wire logic [W-1:0] pinOut,
  input  wire logic [W-1:0] pinOe,
  input  wire logic [W-1:0] srcLevel,
  output logic      [W-1:0] pinLevel
);
  // Source owns every pin the block releases
  assign pinLevel = (pinOe & pinOut) | (~pinOe & srcLevel);
endmodule

// ---- verification/test_pwm_channel_pair_logic.sv ----
// Self-checking bench of the two-unit PWM timer
`timescale 1ns/1ps
module test_pwm_channel_pair_logic;
  localparam logic [7:0] B1 = pcp_pkg::UNIT_STRIDE;
  logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        waitMode = 1'b0, stopMode = 1'b0, breakActive = 1'b0, pready, pslverr, wakeReq, rerr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata, c;
  logic [3:0]  pinOut, pinOe, pinLevel, chanIrq, srcLevel = 4'h0;
  logic [1:0]  wrapIrq;
  logic [15:0] lfsr = 16'h340E;
  int          err_count = 0, tests_run = 0, cycles = 0, m, v, hi;

  pcp_timer_top #(.NUM_UNITS(2)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .waitMode(waitMode), .stopMode(stopMode), .breakActive(breakActive), .chanPinIn(pinLevel),
    .chanPinOut(pinOut), .chanPinOe(pinOe), .wrapIrq(wrapIrq), .chanIrq(chanIrq), .wakeReq(wakeReq));
  pcp_pin_model #(.W(4)) load (.pinOut(pinOut), .pinOe(pinOe), .srcLevel(srcLevel), .pinLevel(pinLevel));

  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] next_rand(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // High cycles over two periods
  function automatic int exp_high(input logic [7:0] k, input int mm, input int vv);
    if (!k[pcp_pkg::CH_TOV]) return 0;
    if (k[pcp_pkg::CH_MAX]) return 2 * (mm + 1);
    return k[pcp_pkg::CH_ELSA] ? 2 * (mm - vv) : 2 * (vv + 1);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic count_high(input int idx, input int len);
    hi = 0;
    repeat (len) begin
      @(posedge ref_clk);
      if (pinOut[idx] === 1'b1) hi++;
    end
  endtask
  task automatic pwm_unit(input int u);
    logic [7:0] b;
    logic [7:0] tbl[4];
    tbl = '{8'h5A, 8'h5E, 8'h58, 8'h5B};
    b = 8'(u * 64);
    lfsr = next_rand(lfsr);
    m = 8 + int'(lfsr[3:0]);
    v = u ? m - 1 : 1 + int'(lfsr[7:4]) % (m - 1);
    apb(1'b1, b + pcp_pkg::OFF_SC, 32'h30);
    apb(1'b1, b + pcp_pkg::OFF_MOD, 32'(m));
    apb(1'b1, b + pcp_pkg::OFF_CH0VAL, 32'(v));
    apb(1'b1, b + pcp_pkg::OFF_CH0SC, 32'h5A);
    apb(1'b1, b + pcp_pkg::OFF_SC, 32'h40);
    foreach (tbl[i]) begin
      apb(1'b1, b + pcp_pkg::OFF_CH0SC, 32'(tbl[i]));
      repeat (m + 1) @(posedge ref_clk);
      count_high(2 * u, 2 * (m + 1));
      check(32'(hi), 32'(exp_high(tbl[i], m, v)));
    end
    check(32'(wrapIrq[u]), 32'h1);
    check(32'(chanIrq[2 * u]), 32'h1);
    $display("pwm unit %0d done", u);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, pcp_pkg::OFF_SC, 32'h0);
    check(rdata, 32'(pcp_pkg::SC_RESET));
    apb(1'b0, pcp_pkg::OFF_MOD, 32'h0);
    check(rdata, 32'(pcp_pkg::MOD_RESET));
    apb(1'b0, 8'h3C, 32'h0);
    check(32'(rerr), 32'h1);
    $display("reset values done");
    pwm_unit(0);
    pwm_unit(1);
    apb(1'b1, B1 + pcp_pkg::OFF_CH0SC, 32'h6A);
    apb(1'b1, B1 + pcp_pkg::OFF_CH1SC, 32'h5A);
    apb(1'b0, B1 + pcp_pkg::OFF_CH1SC, 32'h0);
    check(rdata, 32'h0);
    check(32'(pinOe[3]), 32'h0);
    for (int k = 0; k < 2; k++) begin
      lfsr = next_rand(lfsr);
      v = 1 + int'(lfsr[3:0]) % (m - 1);
      apb(1'b1, B1 + (k ? pcp_pkg::OFF_CH0VAL : pcp_pkg::OFF_CH1VAL), 32'(v));
      repeat (2 * m + 2) @(posedge ref_clk);
      count_high(2, 2 * (m + 1));
      check(32'(hi), 32'(exp_high(8'h6A, m, v)));
    end
    $display("buffered pair done");
    for (int k = 0; k < 2; k++) begin
      stopMode <= (k == 0);
      breakActive <= (k == 1);
      apb(1'b0, B1 + pcp_pkg::OFF_CNT, 32'h0);
      c = rdata;
      repeat (5) @(posedge ref_clk);
      apb(1'b0, B1 + pcp_pkg::OFF_CNT, 32'h0);
      check(rdata, c);
    end
    breakActive <= 1'b0;
    $display("stop and break done");
    apb(1'b1, pcp_pkg::OFF_SC, 32'h60);
    waitMode <= 1'b1;
    repeat (3) @(posedge ref_clk);
    check(32'(wakeReq), 32'h1);
    apb(1'b0, pcp_pkg::OFF_MOD, 32'h0);
    check({rdata[30:0], rerr}, 32'h1);
    waitMode <= 1'b0;
    apb(1'b0, pcp_pkg::OFF_SC, 32'h0);
    check(rdata, 32'hE0);
    breakActive <= 1'b1;
    apb(1'b1, pcp_pkg::OFF_SC, 32'h60);
    apb(1'b0, pcp_pkg::OFF_SC, 32'h0);
    check(rdata, 32'hE0);
    breakActive <= 1'b0;
    apb(1'b1, pcp_pkg::OFF_SC, 32'h60);
    apb(1'b0, pcp_pkg::OFF_SC, 32'h0);
    check({rdata[30:0], wrapIrq[0]}, 32'hC0);
    breakActive <= 1'b1;
    apb(1'b1, pcp_pkg::OFF_BRK, 32'h1);
    apb(1'b0, pcp_pkg::OFF_CH0SC, 32'h0);
    apb(1'b1, pcp_pkg::OFF_CH0SC, 32'h5B);
    breakActive <= 1'b0;
    apb(1'b0, pcp_pkg::OFF_CH0SC, 32'h0);
    check({rdata[30:0], chanIrq[0]}, 32'hB6);
    $display("flags done");
    apb(1'b1, pcp_pkg::OFF_SC, 32'h40);
    apb(1'b1, pcp_pkg::OFF_CH1SC, 32'h44);
    srcLevel <= 4'h2;
    repeat (6) @(posedge ref_clk);
    check({pinOe[1], chanIrq[1]}, 2'h1);
    $display("capture done");
    complete_run();
  end
endmodule

bind pcp_timer_top pcp_timer_chk #(.NUM_UNITS(NUM_UNITS)) chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr), .waitMode(waitMode),
  .stopMode(stopMode), .breakActive(breakActive), .chanPinOut(chanPinOut), .chanPinOe(chanPinOe),
  .wrapIrq(wrapIrq), .wakeReq(wakeReq));
